// ---- common/frac_baud_defines.vh ----
// Constants for the fractional rate generator and transmit timing block
`ifndef FRAC_BAUD_DEFINES_VH
`define FRAC_BAUD_DEFINES_VH

// ****************************************************************
// Register addresses (channel-local)
// ****************************************************************
`define ADDR_TX_HOLDING    4'h0
`define ADDR_DIV_LOW       4'h1
`define ADDR_DIV_HIGH      4'h2
`define ADDR_DIV_FRACTION  4'h3
`define ADDR_MODEM_CTRL    4'h4
`define ADDR_LINE_CTRL     4'h5
`define ADDR_LINE_STATUS   4'h6
`define ADDR_EIGHT_X       4'h7
`define ADDR_FOUR_X        4'h8

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_DIV_LOW        8'h01
`define RST_DIV_HIGH       8'h00
`define RST_DIV_FRACTION   8'h00
`define RST_MODE_SELECT    8'h00
`define RST_MODEM_CTRL     8'h00
`define RST_LINE_CTRL      8'h03
`define MODE_ON            8'hFF

// ****************************************************************
// Field positions
// ****************************************************************
`define MCR_PRESCALE_BIT   7
`define LSR_THR_EMPTY_BIT  5
`define LSR_TSR_EMPTY_BIT  6
`define LCR_PARITY_EN_BIT  3
`define LCR_EVEN_BIT       4
`define LCR_STOP_BIT       2
`define LCR_WLEN_MSB       1
`define WORD_LEN_BASE      4'h5
`define FRAC_BITS          4
`define PRESCALE_DIV       2'h3
`define SAMPLES_16X        5'h10
`define SAMPLES_8X         5'h08
`define SAMPLES_4X         5'h04

`endif

// ---- rtl/frac_baud_tx.v ----
// One serial channel: prescaler, fractional rate generator and transmitter
`timescale 1ns/100ps
`include "frac_baud_defines.vh"

module frac_baud_tx #(
    parameter FIFO_DEPTH = 32,
    parameter PTR_W      = 5
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       busSel,
    input  wire       busWr,
    input  wire       busRd,
    input  wire [3:0] busAddr,
    input  wire [7:0] busWrData,
    output reg  [7:0] busRdData_r,
    output reg        txLine_r,
    output reg        sampleTick_r
);

    // ************************************************************
    // Registers
    // ************************************************************
    reg  [7:0]       divLow_r;
    reg  [7:0]       divHigh_r;
    reg  [7:0]       divFraction_r;
    reg  [7:0]       modemCtrl_r;
    reg  [7:0]       lineCtrl_r;
    reg  [7:0]       eightX_r;
    reg  [7:0]       fourX_r;
    reg  [1:0]       preCnt_r;
    reg              preTick;
    reg  [15:0]      intCnt_r;
    reg  [3:0]       fracAcc_r;
    reg  [4:0]       fracSum;
    reg  [15:0]      intDiv;
    reg  [16:0]      periodLen;
    reg  [7:0]       fifoMem [0:FIFO_DEPTH-1];
    reg  [PTR_W-1:0] wrPtr_r;
    reg  [PTR_W-1:0] rdPtr_r;
    reg  [PTR_W:0]   count_r;
    reg  [7:0]       shift_r;
    reg  [3:0]       bitIdx_r;
    reg  [4:0]       sampleCnt_r;
    reg  [4:0]       samplesPerBit;
    reg              parityAcc_r;
    reg  [5:0]       state_r;
    reg  [5:0]       state_nxt;
    reg  [3:0]       dataBits;
    wire             wrEn;
    wire             fifoPush;
    wire             fifoEmpty;
    wire             fifoFull;
    wire             bitEnd;
    wire             tsrEmpty;

    localparam [5:0] S_IDLE   = 6'h01;
    localparam [5:0] S_START  = 6'h02;
    localparam [5:0] S_DATA   = 6'h04;
    localparam [5:0] S_PARITY = 6'h08;
    localparam [5:0] S_STOP1  = 6'h10;
    localparam [5:0] S_STOP2  = 6'h20;

    // Register write strobe shared by every writable register
    assign wrEn     = busSel & busWr;
    assign fifoPush = wrEn & (busAddr == `ADDR_TX_HOLDING) & ~fifoFull;
    assign fifoEmpty = (count_r == {(PTR_W+1){1'b0}});
    assign fifoFull  = (count_r == FIFO_DEPTH[PTR_W:0]);
    assign tsrEmpty  = (state_r == S_IDLE);

    // Register file; reset restores a divisor of one
    always @(posedge clk) begin
        if (rst) begin
            divLow_r      <= `RST_DIV_LOW;
            divHigh_r     <= `RST_DIV_HIGH;
            divFraction_r <= `RST_DIV_FRACTION;
            modemCtrl_r   <= `RST_MODEM_CTRL;
            lineCtrl_r    <= `RST_LINE_CTRL;
            eightX_r      <= `RST_MODE_SELECT;
            fourX_r       <= `RST_MODE_SELECT;
        end else if (wrEn) begin
            case (busAddr)
                `ADDR_DIV_LOW:      divLow_r      <= busWrData;
                `ADDR_DIV_HIGH:     divHigh_r     <= busWrData;
                `ADDR_DIV_FRACTION: divFraction_r <= busWrData;
                `ADDR_MODEM_CTRL:   modemCtrl_r   <= busWrData;
                `ADDR_LINE_CTRL:    lineCtrl_r    <= busWrData;
                `ADDR_EIGHT_X:      eightX_r      <= busWrData;
                `ADDR_FOUR_X:       fourX_r       <= busWrData;
                default: ;
            endcase
        end
    end

    // Read port; status shows FIFO and shifter emptiness
    always @(posedge clk) begin
        if (rst) begin
            busRdData_r <= 8'h00;
        end else if (busSel & busRd) begin
            case (busAddr)
                `ADDR_DIV_LOW:      busRdData_r <= divLow_r;
                `ADDR_DIV_HIGH:     busRdData_r <= divHigh_r;
                `ADDR_DIV_FRACTION: busRdData_r <= divFraction_r;
                `ADDR_MODEM_CTRL:   busRdData_r <= modemCtrl_r;
                `ADDR_LINE_CTRL:    busRdData_r <= lineCtrl_r;
                `ADDR_EIGHT_X:      busRdData_r <= eightX_r;
                `ADDR_FOUR_X:       busRdData_r <= fourX_r;
                `ADDR_LINE_STATUS: begin
                    busRdData_r <= 8'h00;
                    busRdData_r[`LSR_THR_EMPTY_BIT] <= fifoEmpty;
                    busRdData_r[`LSR_TSR_EMPTY_BIT] <= fifoEmpty
                                                       & tsrEmpty;
                end
                default:            busRdData_r <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // Prescaler and fractional rate generator
    // ************************************************************
    // clk stands for the oscillator input; this channel owns its divider
    always @(posedge clk) begin
        if (rst) begin
            preCnt_r <= 2'h0;
        end else if (preTick) begin
            preCnt_r <= 2'h0;
        end else begin
            preCnt_r <= preCnt_r + 2'h1;
        end
    end

    // Divide by one passes every clock, divide by four every fourth
    always @* begin
        preTick = ~modemCtrl_r[`MCR_PRESCALE_BIT]
                  | (preCnt_r == `PRESCALE_DIV);
    end

    // Integer part from the two bytes; fraction from the low nibble only.
    // A fraction accumulator stretches the period by one input tick each
    // time it overflows, so the average divisor is int + frac/16.
    always @* begin
        intDiv    = {divHigh_r, divLow_r};
        fracSum   = {1'b0, fracAcc_r}
                    + {1'b0, divFraction_r[`FRAC_BITS-1:0]};
        periodLen = {1'b0, intDiv} + {16'h0000, fracSum[4]};
    end

    // Sample tick generator; an integer part of zero ticks on every
    // prescaled clock, since no divisor below one is defined
    always @(posedge clk) begin
        if (rst) begin
            intCnt_r     <= 16'h0001;
            fracAcc_r    <= 4'h0;
            sampleTick_r <= 1'b0;
        end else begin
            sampleTick_r <= 1'b0;
            if (preTick) begin
                if ({1'b0, intCnt_r} >= periodLen) begin
                    intCnt_r     <= 16'h0001;
                    fracAcc_r    <= fracSum[3:0];
                    sampleTick_r <= 1'b1;
                end else begin
                    intCnt_r <= intCnt_r + 16'h0001;
                end
            end
        end
    end

    // ************************************************************
    // Sampling mode; both selects at ones is reserved, 16X is used
    // ************************************************************
    // Odd fractions in 8X mode give half an input tick of jitter per bit,
    // which is accepted rather than compensated.
    always @* begin
        if (eightX_r == `MODE_ON && fourX_r != `MODE_ON)
            samplesPerBit = `SAMPLES_8X;
        else if (fourX_r == `MODE_ON && eightX_r != `MODE_ON)
            samplesPerBit = `SAMPLES_4X;
        else
            samplesPerBit = `SAMPLES_16X;
    end

    assign bitEnd = sampleTick_r && (sampleCnt_r == samplesPerBit - 5'h01);

    // ************************************************************
    // Transmit FIFO behind the holding register
    // ************************************************************
    always @(posedge clk) begin
        if (fifoPush)
            fifoMem[wrPtr_r] <= busWrData;
    end

    // Pointers; a pop occurs when the shifter loads a new character
    // A write while full is dropped rather than overwriting the oldest
    always @(posedge clk) begin
        if (rst) begin
            wrPtr_r <= {PTR_W{1'b0}};
            rdPtr_r <= {PTR_W{1'b0}};
            count_r <= {(PTR_W+1){1'b0}};
        end else begin
            if (fifoPush)
                wrPtr_r <= wrPtr_r + {{(PTR_W-1){1'b0}}, 1'b1};
            if (state_r == S_IDLE && !fifoEmpty)
                rdPtr_r <= rdPtr_r + {{(PTR_W-1){1'b0}}, 1'b1};
            case ({fifoPush, state_r == S_IDLE && !fifoEmpty})
                2'b10:   count_r <= count_r + {{PTR_W{1'b0}}, 1'b1};
                2'b01:   count_r <= count_r - {{PTR_W{1'b0}}, 1'b1};
                default: count_r <= count_r;
            endcase
        end
    end

    // ************************************************************
    // Character framing
    // ************************************************************
    // Next state; one idle cycle always separates two characters
    always @* begin
        dataBits  = {2'b00, lineCtrl_r[`LCR_WLEN_MSB:0]} + `WORD_LEN_BASE;
        state_nxt = state_r;
        case (state_r)
            S_IDLE:   if (!fifoEmpty) state_nxt = S_START;
            S_START:  if (bitEnd) state_nxt = S_DATA;
            S_DATA:   if (bitEnd && bitIdx_r == dataBits - 4'h1)
                          state_nxt = lineCtrl_r[`LCR_PARITY_EN_BIT]
                                      ? S_PARITY : S_STOP1;
            S_PARITY: if (bitEnd) state_nxt = S_STOP1;
            S_STOP1:  if (bitEnd)
                          state_nxt = lineCtrl_r[`LCR_STOP_BIT]
                                      ? S_STOP2 : S_IDLE;
            S_STOP2:  if (bitEnd) state_nxt = S_IDLE;
            default:  state_nxt = S_IDLE;
        endcase
    end

    // Shifter, bit counters and line driver
    always @(posedge clk) begin
        if (rst) begin
            state_r     <= S_IDLE;
            shift_r     <= 8'h00;
            bitIdx_r    <= 4'h0;
            sampleCnt_r <= 5'h00;
            parityAcc_r <= 1'b0;
            txLine_r    <= 1'b1;
        end else begin
            state_r <= state_nxt;
            if (state_r == S_IDLE) begin
                sampleCnt_r <= 5'h00;
                bitIdx_r    <= 4'h0;
                parityAcc_r <= ~lineCtrl_r[`LCR_EVEN_BIT];
                if (!fifoEmpty) begin
                    shift_r  <= fifoMem[rdPtr_r];
                    txLine_r <= 1'b0;
                end else begin
                    txLine_r <= 1'b1;
                end
            end else if (sampleTick_r) begin
                // Bit length counted in sampling clocks
                sampleCnt_r <= bitEnd ? 5'h00
                                      : sampleCnt_r + 5'h01;
                if (bitEnd) begin
                    case (state_nxt)
                        S_DATA: begin
                            txLine_r <= (state_r == S_START)
                                        ? shift_r[0] : shift_r[1];
                            if (state_r == S_DATA) begin
                                shift_r  <= {1'b0, shift_r[7:1]};
                                bitIdx_r <= bitIdx_r + 4'h1;
                            end
                            parityAcc_r <= parityAcc_r
                                ^ ((state_r == S_START)
                                   ? shift_r[0] : shift_r[1]);
                        end
                        S_PARITY: txLine_r <= parityAcc_r;
                        S_IDLE:   txLine_r <= 1'b1;
                        default:  txLine_r <= 1'b1;
                    endcase
                end
            end
        end
    end

endmodule

// ---- test/frac_baud_tx_assertions.sv ----
// Port-level checks on the rate generator and transmitter
`timescale 1ns/100ps
module frac_baud_tx_assertions #(
    parameter FIFO_DEPTH = 32,
    parameter PTR_W      = 5
) (
    input wire       clk,
    input wire       rst,
    input wire       busSel,
    input wire       busWr,
    input wire       busRd,
    input wire [3:0] busAddr,
    input wire [7:0] busWrData,
    input wire [7:0] busRdData_r,
    input wire       txLine_r,
    input wire       sampleTick_r
);
    wire rdCyc = busSel && busRd;
    wire wrCyc = busSel && busWr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Reset must win over any traffic, so this one is not disabled by it
    reset_idle_a: assert property (@(posedge clk) disable iff (1'b0)
        rst |=> txLine_r && !sampleTick_r && busRdData_r == 8'h00)
        else $error("outputs not idle after reset");
    div_low_reset_a: assert property (
        $past(rst) && rdCyc && busAddr == 4'h1 |=> busRdData_r == 8'h01)
        else $error("divisor low byte not one after reset");
    div_hi_reset_a: assert property (
        $past(rst) && rdCyc && (busAddr == 4'h2 || busAddr == 4'h3)
        |=> busRdData_r == 8'h00)
        else $error("divisor high or fraction not zero after reset");
    reg_readback_a: assert property (
        wrCyc && busAddr >= 4'h1 && busAddr <= 4'h3 ##1
        rdCyc && busAddr == $past(busAddr) |=> busRdData_r == $past(busWrData, 2))
        else $error("divisor register lost written value");
    busy_status_a: assert property (
        wrCyc && busAddr == 4'h0 ##1 rdCyc && busAddr == 4'h6
        |=> !busRdData_r[6])
        else $error("transmitter reported empty after a write");
    idle_status_a: assert property (
        $past(rst) && rdCyc && busAddr == 4'h6 |=> busRdData_r[6:5] == 2'b11)
        else $error("empty flags clear after reset");
    first_start_a: assert property (
        $past(rst) && wrCyc && busAddr == 4'h0 |-> ##2 !txLine_r)
        else $error("start bit late after first write");
    bit_min_a: assert property (
        $fell(txLine_r) |-> !txLine_r [*4])
        else $error("low bit shorter than four samples");
endmodule

bind frac_baud_tx frac_baud_tx_assertions #(
    .FIFO_DEPTH(FIFO_DEPTH), .PTR_W(PTR_W)) u_chk (
    .clk(clk), .rst(rst), .busSel(busSel), .busWr(busWr), .busRd(busRd),
    .busAddr(busAddr), .busWrData(busWrData), .busRdData_r(busRdData_r),
    .txLine_r(txLine_r), .sampleTick_r(sampleTick_r));

// ---- test/serial_remote.sv ----
// Remote serial port that frames characters seen on the line
`timescale 1ns/100ps
module serial_remote (
    input  wire       clk,
    input  wire       rst,
    input  wire       line,
    input  wire       tick,
    input  wire [4:0] perBit,
    input  wire [3:0] nBits,
    input  wire       parEn,
    output reg  [7:0] rxData,
    output reg        rxPar,
    output reg        rxStop,
    output reg  [7:0] rxCount
);
    integer i;
    // Counting ticks, not clocks, so bit-time jitter is tolerated
    task waitTicks(input integer n);
        integer k;
        for (k = 0; k < n; k = k + 1) begin
            @(posedge clk);
            while (tick !== 1'b1) @(posedge clk);
        end
    endtask
    // Sample each bit at its middle tick
    initial begin
        rxCount = 8'h00;
        rxPar = 1'b0;
        rxStop = 1'b0;
        rxData = 8'h00;
        forever begin
            @(posedge clk);
            if (!rst && line === 1'b0) begin
                rxData = 8'h00;
                waitTicks(perBit / 2);
                for (i = 0; i < nBits; i = i + 1) begin
                    waitTicks(perBit);
                    rxData[i] = line;
                end
                if (parEn) begin
                    waitTicks(perBit);
                    rxPar = line;
                end
                waitTicks(perBit);
                rxStop = line;
                rxCount = rxCount + 8'h01;
            end
        end
    end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the rate generator and transmitter
`timescale 1ns/100ps
module testbench;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg        busSel = 1'b0;
    reg        busWr = 1'b0;
    reg        busRd = 1'b0;
    reg  [3:0] busAddr = 4'h0;
    reg  [7:0] busWrData = 8'h00;
    wire [7:0] busRdData_r;
    wire       txLine_r;
    wire       sampleTick_r;
    reg  [4:0] perBit = 5'h10;
    reg  [7:0] lcr = 8'h03;
    wire [7:0] rxData;
    wire       rxPar;
    wire       rxStop;
    wire [7:0] rxCount;
    reg  [7:0] rxSeen = 8'h00;
    integer    fails = 0;
    integer    num_checks = 0;
    integer    seed = 85;
    integer    i, cyc;
    reg  [7:0] d, n, v, modem_control_reg;
    reg [23:0] req;
    reg [19:0] dv;
    reg  [7:0] fifoData [0:33];

    always #5 clk = ~clk;

    frac_baud_tx u_frac_baud_tx (.clk(clk), .rst(rst), .busSel(busSel),
        .busWr(busWr), .busRd(busRd), .busAddr(busAddr),
        .busWrData(busWrData), .busRdData_r(busRdData_r),
        .txLine_r(txLine_r), .sampleTick_r(sampleTick_r));
    serial_remote u_serial_remote (.clk(clk), .rst(rst), .line(txLine_r),
        .tick(sampleTick_r), .perBit(perBit), .nBits(lcr[1:0] + 4'h5),
        .parEn(lcr[3]), .rxData(rxData), .rxPar(rxPar), .rxStop(rxStop),
        .rxCount(rxCount));

    task chk(input string name, input [31:0] exp, input [31:0] got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    // Integer part truncated, fraction rounded to sixteenths with carry
    function [19:0] divFor(input [23:0] r);
        reg [8:0] half;
        begin
            half = {1'b0, r[7:0]} + 9'h008;
            divFor = {r[23:8], 4'h0} + {15'h0000, half[8:4]};
        end
    endfunction
    task test_done;
        if (fails == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Writes leave the strobe up; the next access or idle replaces it
    task wr(input [3:0] a, input [7:0] x);
        busSel = 1'b1; busWr = 1'b1; busRd = 1'b0; busAddr = a; busWrData = x;
        @(posedge clk);
        #1;
    endtask
    task rd(input [3:0] a, output [7:0] x);
        busSel = 1'b1; busWr = 1'b0; busRd = 1'b1; busAddr = a;
        @(posedge clk);
        #1 busSel = 1'b0; busRd = 1'b0;
        @(posedge clk);
        #1 x = busRdData_r;
    endtask
    task rstp;
        busSel = 1'b0; busWr = 1'b0; rst = 1'b1;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
    endtask
    task waitRx(input [7:0] x);
        reg [7:0] m;
        m = 8'hFF >> (2'h3 - lcr[1:0]);
        busSel = 1'b0; busWr = 1'b0;
        rxSeen = rxSeen + 8'h01;
        while (rxCount !== rxSeen) @(posedge clk);
        #1;
        chk("rxData", x & m, rxData);
        if (lcr[3]) chk("rxPar", lcr[4] ? ^(x & m) : ~^(x & m), rxPar);
        chk("rxStop", 1, rxStop);
    endtask
    // Clocks spanning sixteen tick periods, after two ticks to settle
    task meas(output integer c);
        integer k;
        k = 0; c = 0; busSel = 1'b0; busWr = 1'b0;
        while (k < 18) begin
            @(posedge clk);
            #1 if (k >= 2) c = c + 1;
            if (sampleTick_r === 1'b1) k = k + 1;
        end
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            if (i > 0) rstp;
            rd((i == 3) ? 4'h6 : i + 1, v);
            chk("resetValue", (i == 0) ? 8'h01 : (i == 3) ? 8'h60 : 8'h00,
                v & ((i == 3) ? 8'h60 : 8'hFF));
        end
        rstp;
        d = $random(seed);
        wr(4'h0, d);
        rd(4'h6, v);
        chk("busyFlag", 0, v[6]);
        waitRx(d);
        for (i = 0; i < 5; i = i + 1) begin
            d = $random(seed);
            wr((i < 3) ? i + 1 : i + 4, d);
            rd((i < 3) ? i + 1 : i + 4, v);
            chk("readBack", d, v);
        end
        rd(4'hF, v);
        chk("unmapped", 0, v);
        wr(4'h7, 8'h00);
        wr(4'h8, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            // Required divisor in 1/256 steps, rounded to sixteenths
            req = {7'h00, i == 3, 16'h0100} + ($random(seed) & 24'h0002FF);
            dv = divFor(req);
            modem_control_reg = i[0] ? 8'h80 : 8'h00;
            d = $random(seed);
            wr(4'h1, dv[11:4]);
            wr(4'h2, dv[19:12]);
            wr(4'h3, {d[7:4], dv[3:0]});
            wr(4'h4, modem_control_reg);
            meas(cyc);
            chk("tickCycles", (modem_control_reg[7] ? 4 : 1) * dv,
                cyc);
        end
        wr(4'h1, 8'h01); wr(4'h2, 8'h00); wr(4'h4, 8'h00);
        for (i = 0; i < 4; i = i + 1) begin
            perBit = i[0] ? 5'h08 : (i == 2) ? 5'h04 : 5'h10;
            d = $random(seed); n = $random(seed); lcr = $random(seed) & 8'h1F;
            // Clear the 4X select first so both never read 0xFF together
            wr(4'h8, 8'h00);
            wr(4'h7, i[0] ? 8'hFF : 8'h00);
            wr(4'h8, (i == 2) ? 8'hFF : 8'h00);
            wr(4'h3, ($random(seed) & 15) | (i == 3));
            wr(4'h5, lcr);
            wr(4'h0, d);
            wr(4'h0, n);
            waitRx(d);
            waitRx(n);
            repeat (200) @(posedge clk);
            #1 rd(4'h6, v);
            chk("emptyFlags", 8'h60, v & 8'h60);
        end
        // One byte into the shifter, 32 queued, the last one dropped
        wr(4'h7, 8'h00);
        wr(4'h8, 8'hFF);
        wr(4'h3, 8'h00);
        perBit = 5'h04;
        for (i = 0; i < 34; i = i + 1) begin
            fifoData[i] = $random(seed);
            wr(4'h0, fifoData[i]);
        end
        for (i = 0; i < 33; i = i + 1) begin
            waitRx(fifoData[i]);
        end
        repeat (200) @(posedge clk);
        #1 chk("overflowDrop", rxSeen, rxCount);
        test_done;
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (80000) @(posedge clk);
        fails = fails + 1;
        test_done;
    end
endmodule
